/* logic/dcvi_pkg.sv */
// Purpose: shared constants for the daisy-chain vectored interrupt link
// Assumes: one clock MCLK at 250 MHz, synchronous active-high reset
// Notes: device end and host end meet in dcvi_if
//
// Summary of operation
// - enabled pending source drives irq_out_n low
// - acknowledge marks next bus cycle as acknowledge
// - vector register driven on data during acknowledge
// - chain_enable_in low blocks every request
// - peripheral-mode host address: page, vector[7:1], bit0 zero
// - external mode: restart opcode expected after acknowledge
// - direct mode: fixed address, no acknowledge cycle
// - peripheral mode: pulse acknowledge, read vector
// - glue routes cpu acknowledge to device input
// - max mode: status 000 means acknowledge
// - multiplexed bus: address first, data second
// - reset selects non-vectored mode until command
// - chain enabled passes unmasked sources only
// - chain out high only if in high, and in vectored mode only if idle
// - chain out low until clear-in-service command
package dcvi_pkg;
    localparam int          DCVI_NSRC      = 8;
    localparam logic [7:0]  DCVI_VEC_RST   = 8'h0f;
    localparam logic [7:0]  DCVI_MASK_RST  = 8'h00;
    localparam logic [2:0]  DCVI_ST_ACK    = 3'h0;
    localparam logic [7:0]  DCVI_RST_BASE  = 8'hc7;
    localparam logic [7:0]  DCVI_RST_STEP  = 8'h08;
    localparam logic [15:0] DCVI_DIRECT_PC = 16'h0038;
    localparam logic [2:0]  DCVI_RST_NUM   = 3'h7;
    // ack held 6 cycles: device syncs, vector launch, host data syncs
    localparam logic [2:0]  DCVI_ACK_LEN   = 3'h5;

    typedef enum logic [1:0] {
        DCVI_EXT_VEC,
        DCVI_DIRECT,
        DCVI_PERIPH_VEC
    } dcvi_cpu_mode_t;
endpackage : dcvi_pkg

/* logic/dcvi_if.sv */
// Purpose: pin-level link between the device end and the host end
// Assumes: both ends on MCLK; data bus resolved from output enables
// Notes: no clocking block; bench joins the ends through this interface
interface dcvi_if;
    logic       irq_out_n;
    logic       ack_in_n;
    logic       rd_n;
    logic [7:0] dev_data_o;
    logic       dev_data_oe;
    logic [7:0] bus_data;

    assign bus_data = dev_data_oe ? dev_data_o : 8'hff;

    modport device (output irq_out_n, output dev_data_o, output dev_data_oe,
                    input ack_in_n, input rd_n);
    modport host   (input irq_out_n, input bus_data,
                    output ack_in_n, output rd_n);
endinterface : dcvi_if

/* logic/dcvi_sync2.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: asynchronous input, reset value given by parameter
// Notes: first stage is read only by the second
module dcvi_sync2 #(
    parameter int   W         = 1,
    parameter logic RST_VAL   = 1'b1
) (
    // clock
    input  wire logic         MCLK,
    input  wire logic         SRST,
    input  wire logic         CE,
    // data
    input  wire logic [W-1:0] D,
    output logic      [W-1:0] Q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s1_next;
    logic [W-1:0] s2_next;

    always_comb begin
        s1_next = D;
        s2_next = s1_reg;
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            s1_reg <= {W{RST_VAL}};
            s2_reg <= {W{RST_VAL}};
        end else if (CE) begin
            s1_reg <= s1_next;
            s2_reg <= s2_next;
        end
    end

    assign Q = s2_reg;
endmodule : dcvi_sync2

/* logic/dcvi_device.sv */
// Purpose: device end: request, chain enable, vector delivery
// Assumes: ack and read strobe arrive from pins; sources are in-domain
// Notes: mode and in-service state are software commands on ports
module dcvi_device
    import dcvi_pkg::*;
#(
    parameter int NSRC = DCVI_NSRC
) (
    // clock and reset
    input  wire logic            MCLK,
    input  wire logic            SRST,
    input  wire logic            CE,
    // sources and software controls
    input  wire logic [NSRC-1:0] SRC_PEND,
    input  wire logic [NSRC-1:0] SRC_MASK_WR_DATA,
    input  wire logic            SRC_MASK_WR,
    input  wire logic [7:0]      VEC_WR_DATA,
    input  wire logic            VEC_WR,
    input  wire logic            SET_VEC_MODE_CMD,
    input  wire logic            CLEAR_IN_SERVICE_CMD,
    // daisy chain
    input  wire logic            CHAIN_ENABLE_IN,
    output logic                 CHAIN_ENABLE_OUT,
    // status
    output logic                 VEC_MODE,
    output logic                 IN_SERVICE,
    output logic                 ACK_CYCLE,
    // link
    dcvi_if.device               lnk
);
    logic [7:0]      vector_register_reg, vector_register_next;
    logic [NSRC-1:0] source_mask_register_reg, source_mask_register_next;
    logic            vec_mode_reg, vec_mode_next;
    logic            in_service_reg, in_service_next;
    logic            ack_cycle_reg, ack_cycle_next;
    logic            ack_prev_reg, ack_prev_next;
    logic            irq_reg, irq_next;
    logic            ack_n_s, rd_n_s, chain_in_s;
    logic            want;

    dcvi_sync2 #(.W(3), .RST_VAL(1'b1)) u_sync (
        .MCLK (MCLK),
        .SRST (SRST),
        .CE   (CE),
        .D    ({lnk.ack_in_n, lnk.rd_n, CHAIN_ENABLE_IN}),
        .Q    ({ack_n_s, rd_n_s, chain_in_s})
    );

    always_comb begin
        vector_register_next      = VEC_WR ? VEC_WR_DATA : vector_register_reg;
        source_mask_register_next = SRC_MASK_WR ? SRC_MASK_WR_DATA
                                                : source_mask_register_reg;
        vec_mode_next  = vec_mode_reg | SET_VEC_MODE_CMD;
        // unmasked pending only, and only with chain enabled
        want           = |(SRC_PEND & source_mask_register_reg) & chain_in_s;
        irq_next       = want;
        ack_prev_next  = ~ack_n_s;
        // falling ack opens the acknowledge cycle, read strobe end closes it
        ack_cycle_next = ack_cycle_reg;
        if (vec_mode_reg && ~ack_n_s && !ack_prev_reg && irq_reg)
            ack_cycle_next = 1'b1;
        else if (ack_cycle_reg && ack_n_s && rd_n_s)
            ack_cycle_next = 1'b0;
        // set wins over clear so a fresh acknowledge is never lost
        in_service_next = in_service_reg;
        if (CLEAR_IN_SERVICE_CMD)
            in_service_next = 1'b0;
        if (vec_mode_reg && ~ack_n_s && !ack_prev_reg && irq_reg)
            in_service_next = 1'b1;
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            vector_register_reg      <= DCVI_VEC_RST;
            source_mask_register_reg <= NSRC'(DCVI_MASK_RST);
            vec_mode_reg             <= 1'b0;
            in_service_reg           <= 1'b0;
            ack_cycle_reg            <= 1'b0;
            ack_prev_reg             <= 1'b0;
            irq_reg                  <= 1'b0;
        end else if (CE) begin
            vector_register_reg      <= vector_register_next;
            source_mask_register_reg <= source_mask_register_next;
            vec_mode_reg             <= vec_mode_next;
            in_service_reg           <= in_service_next;
            ack_cycle_reg            <= ack_cycle_next;
            ack_prev_reg             <= ack_prev_next;
            irq_reg                  <= irq_next;
        end
    end

    // request withdrawn during service; in-service keeps the chain blocked
    assign lnk.irq_out_n   = ~(irq_reg & ~in_service_reg);
    // in vectored mode chain out low while requesting or in service; otherwise follows chain in
    assign CHAIN_ENABLE_OUT = vec_mode_reg ? (chain_in_s & ~irq_reg & ~in_service_reg)
                                           : chain_in_s;
    assign lnk.dev_data_o  = vector_register_reg;
    assign lnk.dev_data_oe = ack_cycle_reg & ~rd_n_s;
    assign VEC_MODE        = vec_mode_reg;
    assign IN_SERVICE      = in_service_reg;
    assign ACK_CYCLE       = ack_cycle_reg;
endmodule : dcvi_device

/* logic/dcvi_host.sv */
// Purpose: host end: cpu interrupt modes and acknowledge glue
// Assumes: irq and data bus sampled through two flops
// Notes: status lines decoded when min_max_select is low
module dcvi_host
    import dcvi_pkg::*;
(
    // clock and reset
    input  wire logic           MCLK,
    input  wire logic           SRST,
    input  wire logic           CE,
    // cpu side
    input  wire dcvi_cpu_mode_t CPU_MODE,
    input  wire logic [7:0]     PAGE_REG,
    input  wire logic           INSTR_DONE,
    input  wire logic           MIN_MAX_SELECT,
    input  wire logic [2:0]     CPU_STATUS,
    input  wire logic           INT_ENABLE,
    output logic                SVC_VALID,
    output logic [15:0]         SVC_ADDR,
    output logic                ADDR_PHASE,
    output logic [15:0]         ADDR_LATCH,
    input  wire logic [15:0]    MUX_AD,
    // link
    dcvi_if.host                lnk
);
    typedef enum {H_IDLE, H_WAIT, H_ACK, H_READ, H_DONE} dcvi_hst_t;
    dcvi_hst_t   st_reg, st_next;
    logic        irq_n_s;
    logic [7:0]  data_s;
    logic        ack_reg, ack_next, rd_reg, rd_next, sv_reg, sv_next;
    logic [15:0] pc_reg, pc_next, al_reg, al_next;
    logic [2:0]  cnt_reg, cnt_next;
    logic        half_reg, half_next;

    dcvi_sync2 #(.W(9), .RST_VAL(1'b1)) u_sync (
        .MCLK (MCLK), .SRST (SRST), .CE (CE),
        .D    ({lnk.irq_out_n, lnk.bus_data}),
        .Q    ({irq_n_s, data_s})
    );

    function automatic logic [15:0] rst_addr(input logic [7:0] op);
        rst_addr = {8'h00, op & ~DCVI_RST_BASE};
    endfunction : rst_addr

    always_comb begin
        st_next = st_reg; ack_next = 1'b0; rd_next = 1'b0; sv_next = 1'b0;
        pc_next = pc_reg; cnt_next = cnt_reg;
        half_next = ~half_reg;
        al_next = half_reg ? al_reg : MUX_AD;
        unique case (st_reg)
            H_IDLE: if (!irq_n_s && INT_ENABLE) st_next = H_WAIT;
            H_WAIT: if (INSTR_DONE) begin
                if (CPU_MODE == DCVI_DIRECT) begin
                    pc_next = DCVI_DIRECT_PC; st_next = H_DONE;
                end else begin
                    // shorter ack would sample the bus before the vector arrives
                    st_next = H_ACK;
                    cnt_next = DCVI_ACK_LEN;
                end
            end
            H_ACK: begin
                ack_next = 1'b1;
                rd_next = 1'b1;
                cnt_next = cnt_reg - 3'h1;
                if (cnt_reg == 3'h0) st_next = H_READ;
            end
            H_READ: begin
                if (CPU_MODE == DCVI_EXT_VEC) pc_next = rst_addr(data_s);
                else pc_next = {PAGE_REG, data_s[7:1], 1'b0};
                st_next = H_DONE;
            end
            H_DONE: begin
                sv_next = 1'b1;
                if (irq_n_s || CPU_MODE != DCVI_DIRECT) st_next = H_IDLE;
            end
            default: st_next = H_IDLE;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (SRST) begin
            st_reg <= H_IDLE; ack_reg <= 1'b0; rd_reg <= 1'b0; sv_reg <= 1'b0;
            pc_reg <= 16'h0000; al_reg <= 16'h0000; cnt_reg <= 3'h0;
            half_reg <= 1'b0;
        end else if (CE) begin
            st_reg <= st_next; ack_reg <= ack_next; rd_reg <= rd_next;
            sv_reg <= sv_next; pc_reg <= pc_next; al_reg <= al_next;
            cnt_reg <= cnt_next; half_reg <= half_next;
        end
    end

    // max mode: status 000 is the acknowledge
    assign lnk.ack_in_n = MIN_MAX_SELECT ? ~ack_reg : (CPU_STATUS != DCVI_ST_ACK);
    assign lnk.rd_n     = ~rd_reg;
    assign SVC_VALID    = sv_reg;
    assign SVC_ADDR     = pc_reg;
    assign ADDR_PHASE   = ~half_reg;
    assign ADDR_LATCH   = al_reg;
endmodule : dcvi_host

/* test/dcvi_properties.sv */
// Purpose: link and chain timing checks between device and host ends
// Assumes: one clock, synchronous active-high reset, 2-flop input syncs
// Notes: ack timing checked in min mode only; max mode acks follow status
module dcvi_props (
    // clock and reset
    input wire logic MCLK,
    input wire logic SRST,
    // link
    input wire logic irq_out_n,
    input wire logic ack_in_n,
    input wire logic rd_n,
    input wire logic dev_data_oe,
    // device and host status
    input wire logic CHAIN_ENABLE_IN,
    input wire logic CHAIN_ENABLE_OUT,
    input wire logic VEC_MODE,
    input wire logic IN_SERVICE,
    input wire logic ACK_CYCLE,
    input wire logic MIN_MAX_SELECT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);
    rst_state_a: assert property ($fell(SRST) |-> irq_out_n && !dev_data_oe && !VEC_MODE)
        else $error("state after reset wrong");
    oe_start_a: assert property ($rose(dev_data_oe) |-> !$past(rd_n, 3))
        else $error("data driven without read strobe");
    oe_hold_a: assert property (dev_data_oe && !rd_n |=> dev_data_oe)
        else $error("data dropped during read strobe");
    oe_release_a: assert property (rd_n [*4] |-> !dev_data_oe)
        else $error("data bus not released");
    oe_mode_a: assert property (dev_data_oe |-> VEC_MODE)
        else $error("vector driven in non-vectored mode");
    ack_cycle_a: assert property ($rose(ACK_CYCLE) |-> !$past(ack_in_n, 3))
        else $error("acknowledge cycle without acknowledge");
    ack_pulse_a: assert property ($fell(ack_in_n) && MIN_MAX_SELECT |-> !ack_in_n [*6] ##1 ack_in_n)
        else $error("acknowledge pulse length wrong");
    ack_cause_a: assert property ($fell(ack_in_n) && MIN_MAX_SELECT |-> !$past(irq_out_n, 2))
        else $error("acknowledge without request");
    chain_out_a: assert property (VEC_MODE && CHAIN_ENABLE_OUT |-> irq_out_n && !IN_SERVICE)
        else $error("chain out high while busy");
    chain_block_a: assert property ((VEC_MODE && !CHAIN_ENABLE_IN) [*4] |-> irq_out_n)
        else $error("request while chain disabled");
    svc_chain_a: assert property (VEC_MODE && IN_SERVICE |-> !CHAIN_ENABLE_OUT)
        else $error("chain out high in service");
    vec_read_c: cover property ($rose(dev_data_oe));
    max_ack_c: cover property ($fell(ack_in_n) && !MIN_MAX_SELECT);
    svc_end_c: cover property ($fell(IN_SERVICE));
endmodule : dcvi_props

/* test/tb_top.sv */
// Purpose: joins device and host ends and runs the interrupt scenarios
// Assumes: inputs change on the falling edge, outputs sampled there too
// Notes: CE and INT_ENABLE held constant
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dcvi_pkg::*;
    logic mclk = 0, srst = 1, mask_wr = 0, vec_wr = 0, vcmd = 0, clr = 0, chain_in = 1;
    logic [7:0] pend = 0, mask_d = 0, vec_d = 0, page = 8'h5a;
    logic instr_done = 0, mm_sel = 1, ack_seen = 0;
    logic [2:0] status = 3'h7;
    dcvi_cpu_mode_t cpu_mode = DCVI_PERIPH_VEC;
    logic chain_out, vec_mode, in_svc, svc_valid, ack_cyc, addr_phase;
    logic [15:0] svc_addr, addr_latch, mux_ad = 16'h0000;
    int failures = 0, checked = 0;
    dcvi_if lnk ();
    dcvi_device i_dcvi_device (.MCLK(mclk), .SRST(srst), .CE(1'b1), .SRC_PEND(pend),
        .SRC_MASK_WR_DATA(mask_d), .SRC_MASK_WR(mask_wr), .VEC_WR_DATA(vec_d), .VEC_WR(vec_wr),
        .SET_VEC_MODE_CMD(vcmd), .CLEAR_IN_SERVICE_CMD(clr), .CHAIN_ENABLE_IN(chain_in),
        .CHAIN_ENABLE_OUT(chain_out), .VEC_MODE(vec_mode), .IN_SERVICE(in_svc), .ACK_CYCLE(ack_cyc),
        .lnk(lnk));
    dcvi_host i_dcvi_host (.MCLK(mclk), .SRST(srst), .CE(1'b1), .CPU_MODE(cpu_mode),
        .PAGE_REG(page), .INSTR_DONE(instr_done), .MIN_MAX_SELECT(mm_sel), .CPU_STATUS(status),
        .INT_ENABLE(1'b1), .SVC_VALID(svc_valid), .SVC_ADDR(svc_addr), .ADDR_PHASE(addr_phase),
        .ADDR_LATCH(addr_latch), .MUX_AD(mux_ad), .lnk(lnk));
    dcvi_props i_dcvi_props (.MCLK(mclk), .SRST(srst), .irq_out_n(lnk.irq_out_n),
        .ack_in_n(lnk.ack_in_n), .rd_n(lnk.rd_n), .dev_data_oe(lnk.dev_data_oe),
        .CHAIN_ENABLE_IN(chain_in), .CHAIN_ENABLE_OUT(chain_out), .VEC_MODE(vec_mode),
        .IN_SERVICE(in_svc), .ACK_CYCLE(ack_cyc), .MIN_MAX_SELECT(mm_sel));
    always #2 mclk = ~mclk;
    always @(negedge mclk) if (lnk.ack_in_n === 1'b0) ack_seen = 1'b1;
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic give_verdict();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    // request, let the cpu finish an instruction, judge the service address
    task automatic serve(input dcvi_cpu_mode_t m, input logic [7:0] v, input logic [15:0] ea);
        int n;
        cpu_mode = m;
        vec_d = v;
        vec_wr = 1;
        @(negedge mclk);
        vec_wr = 0;
        pend = 8'h01;
        for (n = 0; n < 40 && lnk.irq_out_n !== 1'b0; n++) @(negedge mclk);
        // host sees the request two flops later; an earlier done pulse is lost
        repeat (3) @(negedge mclk);
        instr_done = 1;
        @(negedge mclk);
        instr_done = 0;
        for (n = 0; n < 60 && svc_valid !== 1'b1; n++) @(negedge mclk);
        chk("svc_valid", 1, svc_valid);
        chk("svc_addr", ea, svc_addr);
    endtask : serve
    task automatic finish_svc();
        pend = 0;
        clr = 1;
        @(negedge mclk);
        clr = 0;
        repeat (8) @(negedge mclk);
    endtask : finish_svc
    task automatic t_reset();
        chk("irq_out_n", 1, lnk.irq_out_n);
        chk("vec_mode", 0, vec_mode);
        chk("chain_out_nv", 1, chain_out);
    endtask : t_reset
    task automatic t_chain();
        mask_d = 8'h01;
        mask_wr = 1;
        vcmd = 1;
        @(negedge mclk);
        mask_wr = 0;
        vcmd = 0;
        pend = 8'h02;
        repeat (8) @(negedge mclk);
        chk("irq_masked", 1, lnk.irq_out_n);
        chk("chain_out", 1, chain_out);
        chain_in = 0;
        // let the chain pin pass its syncs before the source rises
        repeat (4) @(negedge mclk);
        pend = 8'h01;
        repeat (8) @(negedge mclk);
        chk("irq_blocked", 1, lnk.irq_out_n);
        chk("chain_out_low", 0, chain_out);
        pend = 0;
        chain_in = 1;
        repeat (4) @(negedge mclk);
    endtask : t_chain
    task automatic t_periph();
        serve(DCVI_PERIPH_VEC, 8'ha5, 16'h5aa4);
        chk("in_service", 1, in_svc);
        chk("chain_held", 0, chain_out);
        finish_svc();
        chk("chain_back", 1, chain_out);
    endtask : t_periph
    task automatic t_ext();
        for (int k = 0; k < 8; k++) begin
            serve(DCVI_EXT_VEC, 8'hc7 + 8'(k * 8), {8'h00, 8'(k * 8)});
            finish_svc();
        end
    endtask : t_ext
    task automatic t_direct();
        ack_seen = 0;
        serve(DCVI_DIRECT, 8'h3c, DCVI_DIRECT_PC);
        chk("ack_seen", 0, ack_seen);
        finish_svc();
    endtask : t_direct
    task automatic t_max();
        mm_sel = 0;
        repeat (4) @(negedge mclk);
        chk("ack_idle", 1, lnk.ack_in_n);
        status = DCVI_ST_ACK;
        repeat (4) @(negedge mclk);
        chk("ack_status", 0, lnk.ack_in_n);
        status = 3'h7;
        mm_sel = 1;
        repeat (6) @(negedge mclk);
    endtask : t_max
    // address latched in the first half, same lines carry data in the second
    task automatic t_mux();
        while (addr_phase !== 1'b1) @(negedge mclk);
        mux_ad = 16'h1234;
        @(negedge mclk);
        chk("addr_phase", 0, addr_phase);
        mux_ad = 16'hbeef;
        @(negedge mclk);
        chk("addr_latch", 16'h1234, addr_latch);
        @(negedge mclk);
        chk("addr_next", 16'hbeef, addr_latch);
    endtask : t_mux
    initial begin
        #40000;
        failures++;
        give_verdict();
    end
    initial begin
        repeat (12) @(negedge mclk);
        srst = 0;
        @(negedge mclk);
        t_reset();
        t_chain();
        t_periph();
        t_ext();
        t_direct();
        t_max();
        t_mux();
        give_verdict();
    end
endmodule : tb_top
